// ### logic/aux_i2c_cfg.svh
`ifndef AUX_I2C_CFG_SVH
`define AUX_I2C_CFG_SVH

// Register offsets.
`define CH3_ADDR_OFS 8'h2E
`define CH3_REG_OFS 8'h2F
`define CH3_CTRL_OFS 8'h30
`define CH4_ADDR_OFS 8'h31
`define CH4_REG_OFS 8'h32
`define CH4_WDATA_OFS 8'h33
`define CH4_CTRL_OFS 8'h34

// Reset values.
`define CH3_ADDR_RST 8'h00
`define CH3_REG_RST 8'h00
`define CH3_CTRL_RST 8'h00
`define CH4_ADDR_RST 8'h00
`define CH4_REG_RST 8'h00
`define CH4_WDATA_RST 8'h00
`define CH4_CTRL_RST 8'h00

// Field positions.
`define DIR_BIT 7
`define ENABLE_BIT 7
`define SWAP_BIT 6
`define IRQ_EN_BIT 6
`define SUPPRESS_BIT 5
`define GROUP_BIT 4
`define LEN_MSB 3

// Timing: one quarter of an SCL period.
`define CLK_PERIOD_NS 20
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYCLES (`SCL_QUARTER_NS / `CLK_PERIOD_NS)

// Sensor stream buffer.
`define FIFO_WIDTH 14
`define FIFO_DEPTH 32

`endif

// ### logic/aux_i2c_ch34.sv
// Behaviour
// - Address bit 7 selects read or write.
// - Channel 3 address low bits give target.
// - Channel 4 address low bits give target.
// - Channel 3 start register byte sent.
// - Channel 4 start register byte sent.
// - Channel 3 reads each sample, next free slot.
// - Channel 3 disabled means no periodic transfer.
// - Swap enabled exchanges both bytes of word.
// - Lone leading or trailing byte stays unswapped.
// - Swap clear keeps arrival order.
// - Suppress bit skips the register byte.
// - Grouping bit chooses which address closes pair.
// - Length field sets channel 3 byte count.
// - Channel 4 write sends outgoing data byte.
// - Channel 4 completion interrupt only when enabled.
`include "aux_i2c_cfg.svh"
`default_nettype none

module aux_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output stage keeps the draining side fed from a register.
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

module aux_i2c_ch34 (
  input wire logic clk,
  input wire logic srst,
  // Register port.
  input wire logic reg_write,
  input wire logic reg_read,
  input wire aux_i2c_pkg::byte_t reg_addr,
  input wire aux_i2c_pkg::byte_t reg_wdata,
  output aux_i2c_pkg::byte_t reg_rdata,
  // Sample timing and the slots taken by channels 0 to 2.
  input wire logic sample_tick,
  input wire logic ch0_periodic_enable,
  input wire aux_i2c_pkg::len_t ch0_read_length,
  input wire logic ch1_periodic_enable,
  input wire aux_i2c_pkg::len_t ch1_read_length,
  input wire logic ch2_periodic_enable,
  input wire aux_i2c_pkg::len_t ch2_read_length,
  // Auxiliary bus, open drain.
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // External sensor data stream.
  output logic sensor_valid,
  input wire logic sensor_ready,
  output aux_i2c_pkg::slot_t sensor_slot,
  output aux_i2c_pkg::byte_t sensor_data,
  // Channel 4 results.
  output aux_i2c_pkg::byte_t ch4_read_data,
  output logic ch4_done_irq
);
  import aux_i2c_pkg::*;

  byte_t aux_ch3_target_address;
  byte_t aux_ch3_start_register;
  byte_t aux_ch3_control;
  byte_t aux_ch4_target_address;
  byte_t aux_ch4_start_register;
  byte_t aux_ch4_write_data;
  byte_t aux_ch4_control;
  xfer_state_t state;
  logic [1:0] qtr;
  logic [3:0] bitn;
  len_t idx;
  byte_t shifter;
  logic [7:0] qcount;
  logic tick;
  logic sda_meta;
  logic sda_sync;
  logic nack;
  logic ch3_pending;
  logic cur_ch4;
  logic cur_read;
  logic [6:0] cur_addr;
  byte_t cur_reg;
  len_t cur_len;
  logic cur_suppress;
  logic cur_swap;
  logic cur_grp;
  logic reg_sent;
  logic launch3;
  logic launch4;
  logic stall;
  logic step;
  logic finish;
  logic last;
  logic byte_done;
  logic fifo_valid;
  logic fifo_ready;
  slot_t base;
  slot_t slot;
  byte_t byte_addr;
  logic first_of_pair;
  logic drive_scl_low;
  logic drive_sda_low;

  always_ff @(posedge clk) begin
    if (srst) begin
      aux_ch3_target_address <= `CH3_ADDR_RST;
      aux_ch3_start_register <= `CH3_REG_RST;
      aux_ch3_control <= `CH3_CTRL_RST;
      aux_ch4_target_address <= `CH4_ADDR_RST;
      aux_ch4_start_register <= `CH4_REG_RST;
      aux_ch4_write_data <= `CH4_WDATA_RST;
    end else if (reg_write) begin
      case (reg_addr)
        `CH3_ADDR_OFS: aux_ch3_target_address <= reg_wdata;
        `CH3_REG_OFS: aux_ch3_start_register <= reg_wdata;
        `CH3_CTRL_OFS: aux_ch3_control <= reg_wdata;
        `CH4_ADDR_OFS: aux_ch4_target_address <= reg_wdata;
        `CH4_REG_OFS: aux_ch4_start_register <= reg_wdata;
        `CH4_WDATA_OFS: aux_ch4_write_data <= reg_wdata;
        default: ;
      endcase
    end
  end

  // The start bit of channel 4 drops when its transfer ends; a write wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      aux_ch4_control <= `CH4_CTRL_RST;
    end else if (reg_write && reg_addr == `CH4_CTRL_OFS) begin
      aux_ch4_control <= reg_wdata;
    end else if (finish && cur_ch4) begin
      aux_ch4_control[`ENABLE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `CH3_ADDR_OFS: reg_rdata <= aux_ch3_target_address;
        `CH3_REG_OFS: reg_rdata <= aux_ch3_start_register;
        `CH3_CTRL_OFS: reg_rdata <= aux_ch3_control;
        `CH4_ADDR_OFS: reg_rdata <= aux_ch4_target_address;
        `CH4_REG_OFS: reg_rdata <= aux_ch4_start_register;
        `CH4_WDATA_OFS: reg_rdata <= aux_ch4_write_data;
        `CH4_CTRL_OFS: reg_rdata <= aux_ch4_control;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || qcount == 8'(`SCL_QUARTER_CYCLES - 1)) begin
      qcount <= 8'h00;
    end else begin
      qcount <= qcount + 8'h01;
    end
  end
  assign tick = qcount == 8'(`SCL_QUARTER_CYCLES - 1);

  // A sample request stays pending until launched or channel 3 is disabled; a new request beats the clear.
  always_ff @(posedge clk) begin
    if (srst) begin
      ch3_pending <= 1'b0;
    end else if (sample_tick && aux_ch3_control[`ENABLE_BIT] &&
                 aux_ch3_control[`LEN_MSB:0] != 4'h0) begin
      ch3_pending <= 1'b1;
    end else if (launch3 || !aux_ch3_control[`ENABLE_BIT]) begin
      ch3_pending <= 1'b0;
    end
  end

  assign launch4 = state == ST_IDLE && aux_ch4_control[`ENABLE_BIT];
  assign launch3 = state == ST_IDLE && !launch4 && ch3_pending &&
                   aux_ch3_control[`ENABLE_BIT];

  assign last = idx == cur_len - 4'h1;
  assign byte_done = state == ST_RX && bitn == 4'h7 && qtr == 2'h3;
  assign stall = byte_done && !cur_ch4 && !fifo_ready;
  assign step = tick && !stall;
  assign finish = state == ST_STOP && step && qtr == 2'h3;
  assign fifo_valid = byte_done && tick && !cur_ch4;

  // Slot placement: the first of a pair moves up, the closing byte down.
  assign base = (ch0_periodic_enable ? slot_t'(ch0_read_length) : 6'h00) +
                (ch1_periodic_enable ? slot_t'(ch1_read_length) : 6'h00) +
                (ch2_periodic_enable ? slot_t'(ch2_read_length) : 6'h00);
  assign byte_addr = cur_reg + byte_t'(idx);
  assign first_of_pair = byte_addr[0] == cur_grp;
  always_comb begin
    slot = base + slot_t'(idx);
    if (cur_swap && first_of_pair && !last) begin
      slot = base + slot_t'(idx) + 6'h01;
    end else if (cur_swap && !first_of_pair && idx != 4'h0) begin
      slot = base + slot_t'(idx) - 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_ch4 <= 1'b0;
      cur_read <= 1'b0;
      cur_addr <= 7'h00;
      cur_reg <= 8'h00;
      cur_len <= 4'h0;
      cur_suppress <= 1'b0;
      cur_swap <= 1'b0;
      cur_grp <= 1'b0;
    end else if (launch4) begin
      cur_ch4 <= 1'b1;
      cur_read <= aux_ch4_target_address[`DIR_BIT];
      cur_addr <= aux_ch4_target_address[6:0];
      cur_reg <= aux_ch4_start_register;
      cur_len <= 4'h1;
      cur_suppress <= aux_ch4_control[`SUPPRESS_BIT];
      cur_swap <= 1'b0;
      cur_grp <= 1'b0;
    end else if (launch3) begin
      cur_ch4 <= 1'b0;
      cur_read <= aux_ch3_target_address[`DIR_BIT];
      cur_addr <= aux_ch3_target_address[6:0];
      cur_reg <= aux_ch3_start_register;
      cur_len <= aux_ch3_control[`LEN_MSB:0];
      cur_suppress <= aux_ch3_control[`SUPPRESS_BIT];
      cur_swap <= aux_ch3_control[`SWAP_BIT];
      cur_grp <= aux_ch3_control[`GROUP_BIT];
    end
  end

  // Transfer sequencer; each bit spans four quarter ticks.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      qtr <= 2'h0;
      bitn <= 4'h0;
      idx <= 4'h0;
      shifter <= 8'h00;
      nack <= 1'b0;
      reg_sent <= 1'b0;
    end else if (state == ST_IDLE) begin
      if (launch3 || launch4) begin
        state <= ST_START;
        qtr <= 2'h0;
        idx <= 4'h0;
        reg_sent <= 1'b0;
      end
    end else if (step) begin
      qtr <= qtr + 2'h1;
      if (qtr == 2'h2 && bitn == 4'h8 && state != ST_RX) begin
        nack <= sda_sync;
      end
      if (qtr == 2'h2 && bitn != 4'h8 && state == ST_RX) begin
        shifter <= {shifter[6:0], sda_sync};
      end
      if (qtr == 2'h3) begin
        bitn <= bitn + 4'h1;
        if (state != ST_RX && bitn != 4'h8) begin
          shifter <= {shifter[6:0], 1'b0};
        end
        case (state)
          ST_START: begin
            state <= ST_ADDR;
            bitn <= 4'h0;
            shifter <= {cur_addr, cur_read && (cur_suppress || reg_sent)};
          end
          ST_ADDR: if (bitn == 4'h8) begin
            bitn <= 4'h0;
            if (nack) begin
              state <= ST_STOP;
            end else if (!cur_suppress && !reg_sent) begin
              state <= ST_REG;
              shifter <= cur_reg;
            end else if (cur_read) begin
              state <= ST_RX;
            end else if (cur_ch4) begin
              state <= ST_TX;
              shifter <= aux_ch4_write_data;
            end else begin
              state <= ST_STOP;
            end
          end
          ST_REG: if (bitn == 4'h8) begin
            bitn <= 4'h0;
            reg_sent <= 1'b1;
            if (nack) begin
              state <= ST_STOP;
            end else if (cur_read) begin
              state <= ST_START;
            end else if (cur_ch4) begin
              state <= ST_TX;
              shifter <= aux_ch4_write_data;
            end else begin
              state <= ST_STOP;
            end
          end
          ST_TX: if (bitn == 4'h8) begin
            state <= ST_STOP;
          end
          ST_RX: if (bitn == 4'h8) begin
            bitn <= 4'h0;
            idx <= idx + 4'h1;
            if (last) begin
              state <= ST_STOP;
            end
          end
          ST_STOP: state <= ST_IDLE;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Pin levels: SCL is high in the middle two quarters of every bit, in the last three quarters of the stop, and released in idle.
  always_comb begin
    drive_scl_low = qtr == 2'h0 || qtr == 2'h3;
    drive_sda_low = 1'b0;
    case (state)
      ST_IDLE: drive_scl_low = 1'b0;
      ST_START: drive_sda_low = qtr[1];
      ST_STOP: begin
        drive_scl_low = qtr == 2'h0;
        drive_sda_low = qtr != 2'h3;
      end
      ST_ADDR, ST_REG, ST_TX: drive_sda_low = bitn != 4'h8 && !shifter[7];
      ST_RX: drive_sda_low = bitn == 4'h8 && !last;
      default: drive_scl_low = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= drive_scl_low;
      sda_oe <= drive_sda_low;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ch4_read_data <= 8'h00;
      ch4_done_irq <= 1'b0;
    end else begin
      if (byte_done && tick && cur_ch4) begin
        ch4_read_data <= shifter;
      end
      ch4_done_irq <= finish && cur_ch4 && aux_ch4_control[`IRQ_EN_BIT];
    end
  end

  aux_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) sensor_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data({slot, shifter}),
    .out_valid(sensor_valid),
    .out_ready(sensor_ready),
    .out_data({sensor_slot, sensor_data})
  );

  property p_read_dir;
    @(posedge clk) disable iff (srst) state == ST_RX |-> cur_read;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("Read phase on a write.");

  property p_ch3_addr;
    @(posedge clk) disable iff (srst)
      launch3 |=> cur_addr == $past(aux_ch3_target_address[6:0]) && !cur_ch4;
  endproperty
  a_ch3_addr: assert property (p_ch3_addr) else $error("Channel 3 address lost.");

  property p_ch4_reg;
    @(posedge clk) disable iff (srst)
      launch4 |=> cur_reg == $past(aux_ch4_start_register) && cur_len == 4'h1;
  endproperty
  a_ch4_reg: assert property (p_ch4_reg) else $error("Channel 4 register lost.");

  property p_no_disabled;
    @(posedge clk) disable iff (srst) launch3 |-> aux_ch3_control[`ENABLE_BIT];
  endproperty
  a_no_disabled: assert property (p_no_disabled) else $error("Disabled launch.");

  property p_in_order;
    @(posedge clk) disable iff (srst)
      fifo_valid && !cur_swap |-> slot == base + slot_t'(idx);
  endproperty
  a_in_order: assert property (p_in_order) else $error("Unswapped slot wrong.");

  property p_suppress;
    @(posedge clk) disable iff (srst) state == ST_REG |-> !cur_suppress && !reg_sent;
  endproperty
  a_suppress: assert property (p_suppress) else $error("Register byte sent.");

  property p_length;
    @(posedge clk) disable iff (srst) state == ST_RX |-> idx < cur_len;
  endproperty
  a_length: assert property (p_length) else $error("Read beyond length.");

  property p_irq;
    @(posedge clk) disable iff (srst)
      ch4_done_irq |-> $past(aux_ch4_control[`IRQ_EN_BIT]) && $past(finish) && state == ST_IDLE;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt without enable.");

  property p_stop_release;
    @(posedge clk) disable iff (srst) finish |=> ##1 !sda_oe && !scl_oe;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("Bus not freed.");
endmodule

`default_nettype wire

// ### logic/aux_i2c_pkg.sv
`default_nettype none
package aux_i2c_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] slot_t;
  typedef logic [3:0] len_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_REG, ST_TX, ST_RX, ST_STOP
  } xfer_state_t;
endpackage
`default_nettype wire

// ### test/aux_i2c_slave3_4_channel_config_tb.sv
`default_nettype none

module aux_i2c_slave3_4_channel_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aux_i2c_pkg::*;

  typedef struct {
    byte_t addr;
    byte_t wdata;
    byte_t exp;
  } reg_row_t;

  logic clk, srst, reg_write, reg_read, sample_tick, sensor_valid, sensor_ready, ch4_done_irq;
  byte_t reg_addr, reg_wdata, reg_rdata, sensor_data, ch4_read_data, rd;
  logic ch0_periodic_enable, ch1_periodic_enable, ch2_periodic_enable, seen;
  len_t ch0_read_length, ch1_read_length, ch2_read_length;
  logic scl_o, scl_oe, sda_o, sda_oe, sda_pull, scl, sda;
  slot_t sensor_slot;
  int err_count, comparisons, irq_count;
  slot_t got_slot [$];
  byte_t got_data [$];
  reg_row_t rows [9] = '{'{8'h2E, 8'h81, 8'h81}, '{8'h2F, 8'hC3, 8'hC3},
    '{8'h30, 8'h5F, 8'h5F}, '{8'h31, 8'h7E, 8'h7E}, '{8'h32, 8'hA5, 8'hA5},
    '{8'h33, 8'h3C, 8'h3C}, '{8'h34, 8'h60, 8'h60}, '{8'h35, 8'hFF, 8'h00},
    '{8'h2D, 8'hFF, 8'h00}};

  // Open-drain wires with pull-ups.
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

  aux_i2c_ch34 i_dut (.clk(clk), .srst(srst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_tick(sample_tick), .ch0_periodic_enable(ch0_periodic_enable),
    .ch0_read_length(ch0_read_length), .ch1_periodic_enable(ch1_periodic_enable),
    .ch1_read_length(ch1_read_length), .ch2_periodic_enable(ch2_periodic_enable),
    .ch2_read_length(ch2_read_length), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .sensor_valid(sensor_valid), .sensor_ready(sensor_ready),
    .sensor_slot(sensor_slot), .sensor_data(sensor_data), .ch4_read_data(ch4_read_data),
    .ch4_done_irq(ch4_done_irq));

  aux_target_model #(.OWN_ADDR(7'h1A)) i_target (.scl(scl), .sda(sda), .sda_pull(sda_pull));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (sensor_valid === 1'b1 && sensor_ready === 1'b1) begin
      got_slot.push_back(sensor_slot);
      got_data.push_back(sensor_data);
    end
    if (ch4_done_irq === 1'b1) begin
      irq_count++;
    end
  end

  function automatic byte_t v(input byte_t a);
    return a ^ 8'h5A;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input byte_t a, input byte_t d);
    @(negedge clk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  task automatic reg_rd(input byte_t a, output byte_t d);
    @(negedge clk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask

  task automatic tick();
    @(negedge clk);
    sample_tick = 1'b1;
    @(negedge clk);
    sample_tick = 1'b0;
  endtask

  // Waits for the target to see the given number of stop conditions.
  // The master returns to idle one quarter bit after the stop, so the wait runs past that.
  task automatic wait_stop(input int n);
    int k;
    k = 0;
    while (i_target.stop_count < n && k < 40000) begin
      @(negedge clk);
      k++;
    end
    check(8'(i_target.stop_count), 8'(n));
    repeat (150) @(negedge clk);
  endtask

  task automatic check_log(input byte_t exp[$]);
    check(8'(i_target.rx_log.size()), 8'(exp.size()));
    foreach (exp[i]) begin
      if (i < i_target.rx_log.size()) begin
        check(i_target.rx_log[i], exp[i]);
      end
    end
    i_target.rx_log.delete();
  endtask

  task automatic check_sensor(input byte_t es[$], input byte_t ed[$]);
    check(8'(got_slot.size()), 8'(es.size()));
    foreach (es[i]) begin
      if (i < got_slot.size()) begin
        check({2'b00, got_slot[i]}, es[i]);
        check(got_data[i], ed[i]);
      end
    end
    got_slot.delete();
    got_data.delete();
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    {srst, reg_write, reg_read, sample_tick, sensor_ready} = 5'b10001;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {ch0_periodic_enable, ch1_periodic_enable, ch2_periodic_enable} = 3'b000;
    {ch0_read_length, ch1_read_length, ch2_read_length} = 12'h000;
    err_count = 0;
    comparisons = 0;
    irq_count = 0;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      reg_rd(rows[i].addr, rd);
      check(rd, 8'h00);
    end
    foreach (rows[i]) begin
      reg_wr(rows[i].addr, rows[i].wdata);
      reg_rd(rows[i].addr, rd);
      check(rd, rows[i].exp);
    end
    // A reset in mid-run clears what was written.
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    reg_rd(8'h33, rd);
    check(rd, 8'h00);
    // A disabled channel 3 ignores the sample tick.
    reg_wr(8'h2E, 8'h9A);
    reg_wr(8'h2F, 8'h21);
    reg_wr(8'h30, 8'h04);
    tick();
    seen = 1'b0;
    repeat (600) begin
      @(negedge clk);
      seen = seen | scl_oe | sda_oe;
    end
    check({7'h00, seen}, 8'h00);
    // Channel 4 write with the completion interrupt enabled.
    reg_wr(8'h31, 8'h1A);
    reg_wr(8'h32, 8'h10);
    reg_wr(8'h33, 8'hA5);
    reg_wr(8'h34, 8'hC0);
    wait_stop(1);
    check_log('{8'h34, 8'h10, 8'hA5});
    check(8'(irq_count), 8'h01);
    // The start bit has dropped at completion while the interrupt enable stays.
    reg_rd(8'h34, rd);
    check(rd, 8'h40);
    // Channel 4 read without the register byte and without interrupt.
    reg_wr(8'h31, 8'h9A);
    reg_wr(8'h34, 8'hA0);
    wait_stop(2);
    check_log('{8'h35});
    check(ch4_read_data, v(8'h11));
    check(8'(irq_count), 8'h01);
    // A target that does not answer ends the frame after its address.
    reg_wr(8'h31, 8'h22);
    reg_wr(8'h34, 8'h80);
    wait_stop(3);
    check_log('{8'h44});
    // Channel 3 swapped read behind five slots, stream stalled meanwhile.
    {ch0_periodic_enable, ch1_periodic_enable, ch2_periodic_enable} = 3'b101;
    {ch0_read_length, ch1_read_length, ch2_read_length} = 12'h352;
    sensor_ready = 1'b0;
    reg_wr(8'h30, 8'hC4);
    tick();
    wait_stop(4);
    reg_wr(8'h30, 8'h44);
    check(8'(got_slot.size()), 8'h00);
    sensor_ready = 1'b1;
    repeat (20) @(negedge clk);
    check_log('{8'h34, 8'h21, 8'h35});
    // The stream keeps arrival order; each byte carries its swapped slot.
    check_sensor('{8'h05, 8'h07, 8'h06, 8'h08},
      '{v(8'h21), v(8'h22), v(8'h23), v(8'h24)});
    // Channel 3 unswapped read with the register byte suppressed.
    {ch0_periodic_enable, ch1_periodic_enable, ch2_periodic_enable} = 3'b010;
    ch1_read_length = 4'h6;
    reg_wr(8'h30, 8'hB2);
    tick();
    wait_stop(5);
    reg_wr(8'h30, 8'h32);
    repeat (20) @(negedge clk);
    check_log('{8'h35});
    check_sensor('{8'h06, 8'h07}, '{v(8'h25), v(8'h26)});
    // Open-drain pins only ever pull low.
    check({6'h00, scl_o, sda_o}, 8'h00);
    tally_and_finish();
  end
endmodule

`default_nettype wire

// ### test/aux_target_model.sv
`default_nettype none

module aux_target_model #(
  parameter logic [6:0] OWN_ADDR = 7'h1A
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:255];
  logic [7:0] ptr;
  logic [7:0] shift;
  logic [7:0] out;
  logic active;
  logic first;
  logic match;
  logic rd;
  logic tx;
  logic mack;
  int cnt;
  int nwr;
  int stop_count;
  logic [7:0] rx_log [$];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    sda_pull = 1'b0;
    active = 1'b0;
    tx = 1'b0;
    match = 1'b0;
    ptr = 8'h00;
    stop_count = 0;
  end

  // A start or repeated start opens a fresh address phase.
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      first = 1'b1;
      tx = 1'b0;
      cnt = -1;
      sda_pull = 1'b0;
    end
  end

  // A stop closes the frame and frees the data line.
  always @(posedge sda) begin
    if (scl === 1'b1 && active) begin
      active = 1'b0;
      tx = 1'b0;
      sda_pull = 1'b0;
      stop_count++;
    end
  end

  // Bits are taken while the clock is high, most significant first.
  always @(posedge scl) begin
    if (active) begin
      if (cnt < 8) begin
        shift = {shift[6:0], sda};
      end else begin
        mack = ~sda;
      end
    end
  end

  // The data line only changes while the clock is low.
  always @(negedge scl) begin
    if (active) begin
      if (cnt < 7) begin
        cnt++;
        if (tx) begin
          sda_pull = ~out[7 - cnt];
        end
      end else if (cnt == 7) begin
        cnt = 8;
        if (tx) begin
          sda_pull = 1'b0;
        end else begin
          rx_log.push_back(shift);
          if (first) begin
            match = (shift[7:1] == OWN_ADDR);
            rd = shift[0];
            nwr = 0;
          end else if (nwr == 0) begin
            ptr = shift;
            nwr++;
          end else begin
            mem[ptr] = shift;
            ptr++;
          end
          sda_pull = match;
        end
      end else begin
        cnt = 0;
        if ((first && match && rd) || (tx && mack)) begin
          tx = 1'b1;
          out = mem[ptr];
          ptr++;
          sda_pull = ~out[7];
        end else begin
          tx = 1'b0;
          sda_pull = 1'b0;
        end
        first = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire
